// [bench/mac_partner.sv]
`timescale 1ns/1ps
module mac_partner
    import phy_mac_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset
    input wire logic clkIn, // tx timing clock
    input wire logic send, // frame active
    output phy_mac_pkg::txsym_t txIn, // tx pins
    input wire logic hostOe, // host drives pin
    input wire logic hostBit, // host bit
    input wire logic mdioOe, // device drives
    input wire logic mdioOut, // device bit
    output logic mdioIn // pin level
);
    logic clkQ;
    // Pull-up wins when nobody drives
    assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);
    // Change after the falling edge; idle data flips every symbol
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            txIn <= '0;
            clkQ <= 1'b0;
        end else begin
            clkQ <= clkIn;
            if (clkQ && !clkIn) begin
                txIn.en <= send;
                txIn.data <= send ? txIn.data + 4'h1
                                  : ~txIn.data;
            end
        end
    end
endmodule

// [bench/phy_mac_chk.sv]
`timescale 1ns/1ps
module phy_mac_chk
    import phy_mac_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset
    input wire logic modeStrap, // mode pin
    input wire logic fullDuplex, // duplex
    input wire phy_mac_pkg::rxsym_t lineRx, // line symbol
    input wire logic lineRxStrobe, // symbol ready
    input wire phy_mac_pkg::txsym_t txOut, // tx capture
    input wire logic txStrobe, // tx pulse
    input wire logic txClk, // tx clock
    input wire logic rxClk, // rx clock
    input wire phy_mac_pkg::rxsym_t rxOut, // rx pins
    input wire logic mdc, // mgmt clock
    input wire logic mdcRise, // mgmt rise
    input wire logic mdioDrive, // drive request
    input wire logic mdioBit, // drive value
    input wire logic mdioOut, // pin value
    input wire logic mdioOe // pin enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [1:0] ageQ;
    logic rmiiQ;
    // Own copy of the latched mode; settles on the first edge after release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ageQ <= 2'h0;
            rmiiQ <= 1'b0;
        end else begin
            if (ageQ == 2'h0) rmiiQ <= modeStrap;
            if (ageQ != 2'h3) ageQ <= ageQ + 2'h1;
        end
    end
    rx_valid_a: assert property (lineRxStrobe |=>
        rxOut.dv == $past(lineRx.dv)) else $error("rx valid wrong");
    rx_error_a: assert property (lineRxStrobe |=>
        rxOut.er == $past(lineRx.er & lineRx.dv)) else $error("rx er");
    rx_fill_a: assert property (lineRxStrobe && lineRx.er &&
        lineRx.dv |=> rxOut.data == (rmiiQ ? {2'b00, RX_ERR_FILL[1:0]}
        : RX_ERR_FILL)) else $error("no fill");
    rmii_rx_a: assert property (rmiiQ && lineRxStrobe |=>
        rxOut.data[3:2] == 2'h0) else $error("rmii upper rx bits");
    col_full_a: assert property (lineRxStrobe && fullDuplex |=>
        !rxOut.col) else $error("collision in full duplex");
    rmii_clk_a: assert property (rmiiQ && ageQ == 2'h3 |->
        !txClk && !rxClk) else $error("clock out in rmii");
    rmii_tx_a: assert property (rmiiQ && txStrobe |->
        txOut.data[3:2] == 2'h0) else $error("rmii upper bits");
    mdc_rise_a: assert property ($rose(mdc) |-> ##[1:4] mdcRise)
        else $error("mdc rise lost");
    mdio_drive_a: assert property (mdioDrive |=> mdioOe &&
        mdioOut == $past(mdioBit)) else $error("mdio drive wrong");
endmodule
bind phy_mac_side phy_mac_chk i_phy_mac_chk (.*);

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import phy_mac_pkg::*;
    logic sys_clk = 0, rstn = 0, refClockPin = 0, lineClk = 0, mdc = 0;
    logic modeStrap = 0, fullDuplex = 1, speed100 = 1, lineRxStrobe = 0;
    logic mdioDrive = 0, mdioBit = 0, hostOe = 0, hostBit = 0, send = 0;
    logic txStrobe, txClk, rxClk, mdcRise, mdioSample, mdioOut, mdioOe, mdioIn;
    rxsym_t lineRx = '0;
    rxsym_t rxOut;
    txsym_t txIn, txOut;
    int errors = 0, checks = 0;
    initial forever #25 sys_clk = ~sys_clk;
    initial begin #60 forever #200 refClockPin = ~refClockPin; end
    initial begin #137 forever #200 lineClk = ~lineClk; end
    phy_mac_side i_phy_mac_side (.*);
    mac_partner i_mac_partner (.*, .clkIn(modeStrap ? refClockPin : txClk));
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task rst(input logic m);
        rstn <= 0;
        modeStrap <= m;
        send <= 0;
        tick(10);
        rstn <= 1;
        tick(3);
    endtask
    task test_tx(input logic m, input logic s);
        logic [3:0] msk, prev;
        logic pt, pr;
        int nt, nr;
        msk = m ? 4'h3 : 4'hf;
        speed100 <= s;
        send <= 1;
        for (int i = 0; i < 6; i++) begin
            repeat (200) begin
                @(posedge sys_clk);
                if (txStrobe === 1'b1) break;
            end
            if (i > 1) begin
                chk(8'({txOut.en, txOut.data & msk}),
                    8'({1'b1, (prev + 4'h1) & msk}));
            end
            prev = txOut.data;
        end
        nt = 0;
        nr = 0;
        pt = txClk;
        pr = rxClk;
        // Clocks are pin divisions of exact periods, so counts are exact
        for (int i = 0; i < (s ? 64 : 640); i++) begin
            @(posedge sys_clk);
            nt += int'(txClk & ~pt);
            nr += int'(rxClk & ~pr);
            pt = txClk;
            pr = rxClk;
        end
        chk(8'(nt), m ? 8'h0 : 8'h4);
        chk(8'(nr), m ? 8'h0 : (s ? 8'h8 : 8'h50));
        $display("test tx done");
    endtask
    task test_rx(input logic m, input int cnt);
        rxsym_t s, e;
        for (int i = 0; i < cnt; i++) begin
            s = '0;
            s.dv = i < 2 || i == 4;
            s.er = i == 1 || i == 3;
            s.crs = i != 2 && !m;
            s.data = 4'(i + 1);
            e = s;
            e.er = s.er & s.dv;
            e.crs = s.crs | (m & s.dv);
            e.col = i == 4;
            if (!s.dv) e.data = 4'h0;
            if (e.er) e.data = RX_ERR_FILL;
            if (m) e.data[3:2] = 2'b00;
            @(posedge sys_clk);
            lineRx <= s;
            lineRxStrobe <= 1;
            fullDuplex <= i != 4;
            @(posedge sys_clk);
            lineRxStrobe <= 0;
            tick(2);
            chk(rxOut, e);
        end
        fullDuplex <= 1;
        $display("test rx done");
    endtask
    task test_mgmt(input logic ho, input logic hb, input logic dd,
                   input logic x);
        @(posedge sys_clk);
        hostOe <= ho;
        hostBit <= hb;
        mdioDrive <= dd;
        mdioBit <= hb;
        tick(2);
        mdc <= 1;
        tick(4);
        mdc <= 0;
        tick(4);
        chk(8'({mdioOe, mdioSample}), 8'({dd, x}));
    endtask
    task summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        rst(0);
        test_tx(0, 1);
        test_tx(0, 0);
        test_rx(0, 5);
        test_mgmt(1, 1, 0, 1);
        test_mgmt(1, 0, 0, 0);
        test_mgmt(0, 0, 1, 0);
        test_mgmt(0, 1, 0, 1);
        $display("test mgmt done");
        rst(1);
        test_tx(1, 1);
        test_rx(1, 2);
        summarize();
    end
    initial begin
        #500000;
        errors++;
        summarize();
    end
endmodule

// [src/phy_mac_pkg.sv]
package phy_mac_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 20000000;
    // Sync stages for outside inputs
    localparam int SYNC_STAGES = 2;
    // Corruption nibble driven while a receive error is flagged
    localparam logic [3:0] RX_ERR_FILL = 4'he;
    localparam logic [3:0] MDIO_REG_RESET = 4'h0;
    // Management data bits per frame
    localparam int MGMT_DATA_BITS = 16;
    // Reference edges per MII clock step at 10 Mb/s versus 100 Mb/s
    localparam int SLOW_DIV = 10;
    // Management pin level when nobody drives it (pull-up)
    localparam logic MDIO_IDLE = 1'b1;

    typedef enum {
        MODE_MII,
        MODE_RMII
    } ifmode_t;

    typedef struct packed {
        logic en;
        logic [3:0] data;
    } txsym_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic crs;
        logic col;
        logic [3:0] data;
    } rxsym_t;

endpackage

// [src/phy_mac_side.sv]
`timescale 1ns/1ps
// Summary of operation
// - Management clock is unrelated to data clocks; treated as async.
// - Management data pin is shared; host and device drive in turn.
// - MII transmit clock is 25 MHz or 2.5 MHz by link speed.
// - MII transmit clock keeps fixed phase to the reference clock.
// - RMII leaves transmit clock unused; reference times both ways; here receive follows lineRxStrobe.
// - Transmit enable high marks data; MII four bits, RMII two.
// - MII transmit nibble captured on rising transmit clock edge.
// - RMII transmit dibit captured on the reference clock.
// - MII receive clock 25 or 2.5 MHz, from line data stream.
// - Receive data valid marks valid receive data, not carrier.
// - Receive error raised on error symbol, on the receive timing.
// - Receive data corrupted during a receive error.
// - Receive data presented per clock, valid while data valid.
// - MII carrier sense when medium busy; RMII merges with valid.
// - Collision low in full duplex; half duplex both busy; not RMII.
module phy_mac_side
    import phy_mac_pkg::*;
(
    input wire logic sys_clk, // System clock, 20 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic refClockPin, // Reference clock pin (async)
    input wire logic lineClk, // Clock recovered from line (async)
    input wire logic modeStrap, // 1 selects RMII, sampled at reset
    input wire logic speed100, // 1 = 100 Mb/s link
    input wire logic fullDuplex, // 1 = full duplex
    input wire phy_mac_pkg::txsym_t txIn, // MAC transmit pins (async)
    output phy_mac_pkg::txsym_t txOut, // Captured transmit symbol
    output logic txStrobe, // Pulse: new transmit symbol
    input wire phy_mac_pkg::rxsym_t lineRx, // Decoded line symbol
    input wire logic lineRxStrobe, // Pulse: line symbol ready
    output logic txClk, // MII transmit clock out
    output logic rxClk, // MII receive clock out
    output phy_mac_pkg::rxsym_t rxOut, // MAC receive pins
    input wire logic mdc, // Management clock pin (async)
    input wire logic mdioIn, // Management data pin level
    input wire logic mdioDrive, // Core wants to drive data pin
    input wire logic mdioBit, // Core bit for the data pin
    output logic mdcRise, // Pulse: management clock rose
    output logic mdioSample, // Data pin level at last rise
    output logic mdioOut, // Data pin output value
    output logic mdioOe // Data pin output enable, high drives
);
    import phy_mac_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Bit order: ref, line, mdc, mdio, tx en, tx data[3:0]
    localparam int NS = 9;
    logic [NS-1:0] syncA_q, syncA_d, syncB_q, syncB_d;
    logic [NS-1:0] rawIn;
    assign rawIn = {refClockPin, lineClk, mdc, mdioIn, txIn.en, txIn.data};
    always_comb begin
        syncA_d = rawIn;
        syncB_d = syncA_q;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
        end
    end

    // ------------------------------------------------------------
    // Edge history and mode strap
    // ------------------------------------------------------------
    logic refD_q, refD_d, mdcD_q, mdcD_d;
    logic refRise;
    ifmode_t mode_q, mode_d;
    logic strapDone_q, strapDone_d;
    logic div_q, div_d;
    logic [3:0] divCnt_q, divCnt_d;
    logic divStep;
    always_comb begin
        refD_d = syncB_q[8];
        mdcD_d = syncB_q[6];
        refRise = syncB_q[8] & ~refD_q;
        mdcRise = syncB_q[6] & ~mdcD_q;
        // Strap caught once after reset release, held until next reset
        strapDone_d = 1'b1;
        mode_d = mode_q;
        if (!strapDone_q) begin
            mode_d = modeStrap ? MODE_RMII : MODE_MII;
        end
        // At 10 Mb/s the divider steps once per SLOW_DIV reference edges
        divStep = refRise & speed100;
        divCnt_d = divCnt_q;
        if (speed100) begin
            divCnt_d = 4'h0;
        end else if (refRise) begin
            if (divCnt_q == 4'(SLOW_DIV - 1)) begin
                divCnt_d = 4'h0;
                divStep = 1'b1;
            end else begin
                divCnt_d = divCnt_q + 4'h1;
            end
        end
        // Divider steps halved for MII clock: phase locked to reference
        div_d = divStep ? ~div_q : div_q;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            refD_q <= 1'b0;
            mdcD_q <= 1'b0;
            mode_q <= MODE_MII;
            strapDone_q <= 1'b0;
            div_q <= 1'b0;
            divCnt_q <= 4'h0;
        end else begin
            refD_q <= refD_d;
            mdcD_q <= mdcD_d;
            mode_q <= mode_d;
            strapDone_q <= strapDone_d;
            div_q <= div_d;
            divCnt_q <= divCnt_d;
        end
    end

    // ------------------------------------------------------------
    // Transmit capture
    // ------------------------------------------------------------
    logic txTick;
    txsym_t txOut_d;
    logic txStrobe_d;
    always_comb begin
        // MII: rising edge of our own transmit clock; RMII: reference
        if (mode_q == MODE_RMII) begin
            txTick = refRise;
        end else begin
            txTick = divStep & ~div_q;
        end
        txOut_d = txOut;
        txStrobe_d = txTick;
        if (txTick) begin
            txOut_d.en = syncB_q[4];
            txOut_d.data = syncB_q[3:0];
            if (mode_q == MODE_RMII) begin
                txOut_d.data[3:2] = 2'b00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            txOut <= '0;
            txStrobe <= 1'b0;
        end else begin
            txOut <= txOut_d;
            txStrobe <= txStrobe_d;
        end
    end

    // ------------------------------------------------------------
    // Clock outputs and receive path
    // ------------------------------------------------------------
    // Limitation: reference must run at twice the fast MII clock rate
    logic txClk_d, rxClk_d;
    rxsym_t rxOut_d;
    always_comb begin
        txClk_d = (mode_q == MODE_MII) ? div_q : 1'b0;
        rxClk_d = (mode_q == MODE_MII) ? syncB_q[7] : 1'b0;
        rxOut_d = rxOut;
        if (lineRxStrobe) begin
            rxOut_d.dv = lineRx.dv;
            rxOut_d.er = lineRx.er & lineRx.dv;
            rxOut_d.data = lineRx.data;
            if (lineRx.er) begin
                rxOut_d.data = RX_ERR_FILL;
            end
            if (!lineRx.dv) begin
                rxOut_d.data = 4'h0;
            end
            if (mode_q == MODE_RMII) begin
                // Mask last so the error fill keeps the two-bit width
                rxOut_d.data[3:2] = 2'b00;
                rxOut_d.crs = lineRx.crs | lineRx.dv;
                rxOut_d.col = 1'b0;
            end else begin
                rxOut_d.crs = lineRx.crs;
                rxOut_d.col = ~fullDuplex & lineRx.crs & txOut.en;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            txClk <= 1'b0;
            rxClk <= 1'b0;
            rxOut <= '0;
        end else begin
            txClk <= txClk_d;
            rxClk <= rxClk_d;
            rxOut <= rxOut_d;
        end
    end

    // ------------------------------------------------------------
    // Management pin
    // ------------------------------------------------------------
    logic mdioSample_d, mdioOut_d, mdioOe_d;
    always_comb begin
        mdioSample_d = mdcRise ? syncB_q[5] : mdioSample;
        mdioOut_d = mdioBit;
        mdioOe_d = mdioDrive;
    end

    // Idle level after reset so no false low is reported
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mdioSample <= MDIO_IDLE;
            mdioOut <= MDIO_IDLE;
            mdioOe <= 1'b0;
        end else begin
            mdioSample <= mdioSample_d;
            mdioOut <= mdioOut_d;
            mdioOe <= mdioOe_d;
        end
    end

endmodule
